// >>> hdl/cmp_pkg.sv
// Package: register map, field positions and carrier types of the comparator control block
package cmp_pkg;

  localparam logic [5:0] CTRL_STATUS_OFFSET = 6'h08;
  localparam logic [5:0] SFIO_OFFSET        = 6'h20;

  localparam int CS_DISABLE_BIT   = 7;
  localparam int CS_REFSEL_BIT    = 6;
  localparam int CS_OUTPUT_BIT    = 5;
  localparam int CS_FLAG_BIT      = 4;
  localparam int CS_IRQEN_BIT     = 3;
  localparam int CS_CAPTURE_BIT   = 2;
  localparam int CS_MODE_HI_BIT   = 1;
  localparam int CS_MODE_LO_BIT   = 0;
  localparam int SFIO_MUXEN_BIT   = 3;

  localparam logic [1:0] MODE_TOGGLE   = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALLING  = 2'h2;
  localparam logic [1:0] MODE_RISING   = 2'h3;

  localparam logic       RESET_BIT   = 1'h0;
  localparam logic [1:0] RESET_MODE  = 2'h0;
  localparam logic [2:0] RESET_CHAN  = 3'h0;
  localparam int         SYNC_STAGES = 2;

  // Processor I/O bus access, one cycle per strobe
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cmp_io_req_s;

  // Analog front-end steering toward the comparator macro
  typedef struct packed {
    logic       power_down;
    logic       pos_is_bandgap;
    logic       neg_is_channel;
    logic [2:0] neg_channel;
  } cmp_analog_sel_s;

endpackage

// >>> hdl/cmp_sync.sv
// Two-flop synchroniser for a single asynchronous level
`timescale 1ns/1ps
module cmp_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic [STAGES-1:0] chain_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain_r[STAGES-1];

endmodule

// >>> hdl/cmp_ctrl.sv
// Comparator control logic: input steering, result sync, edge events and capture routing
//
// Functional notes
// R1: Output bit high when positive exceeds negative
// R2: Mux enable and converter off select channel
// R3: Reference select swaps positive input for bandgap
// R4: Raw result synchronised, one to two cycles
// R5: Event flag set on matching output edge
// R6: Mode 00 toggle, 10 fall, 11 rise
// R7: Interrupt only with enable and global enable
// R8: Flag cleared by vector taken or write-one
// R9: Disable bit powers comparator off or on
// R10: Software clears irq enable before disable change
// R11: Software clears irq enable before mode change
// R12: Capture route feeds timer capture front end
// R13: Software sets timer capture irq enable too
// R14: Edge from current versus previous synced sample
`timescale 1ns/1ps
module cmp_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire cmp_pkg::cmp_io_req_s     io_req,
  output logic [7:0]                    io_rdata,
  input  wire logic                     converter_enable,
  input  wire logic [2:0]               channel_select_field,
  input  wire logic                     global_irq_enable,
  input  wire logic                     irq_vector_taken,
  input  wire logic                     raw_compare,
  output cmp_pkg::cmp_analog_sel_s      analog_sel,
  output logic                          compare_irq,
  output logic                          capture_trigger
);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic       compare_disable_r;
  logic       reference_select_r;
  logic       compare_irq_enable_r;
  logic       capture_route_enable_r;
  logic [1:0] event_mode_select_r;
  logic       compare_mux_enable_r;
  logic       compare_event_flag_r;

  logic cs_wr;
  logic sf_wr;
  assign cs_wr = io_req.wr && (io_req.addr == cmp_pkg::CTRL_STATUS_OFFSET);
  assign sf_wr = io_req.wr && (io_req.addr == cmp_pkg::SFIO_OFFSET);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_disable_r      <= cmp_pkg::RESET_BIT;
      reference_select_r     <= cmp_pkg::RESET_BIT;
      compare_irq_enable_r   <= cmp_pkg::RESET_BIT;
      capture_route_enable_r <= cmp_pkg::RESET_BIT;
      event_mode_select_r    <= cmp_pkg::RESET_MODE;
    end else if (cs_wr) begin
      compare_disable_r      <= io_req.wdata[cmp_pkg::CS_DISABLE_BIT]; // R9
      reference_select_r     <= io_req.wdata[cmp_pkg::CS_REFSEL_BIT];
      compare_irq_enable_r   <= io_req.wdata[cmp_pkg::CS_IRQEN_BIT];
      capture_route_enable_r <= io_req.wdata[cmp_pkg::CS_CAPTURE_BIT];
      event_mode_select_r    <= io_req.wdata[cmp_pkg::CS_MODE_HI_BIT:cmp_pkg::CS_MODE_LO_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_mux_enable_r <= cmp_pkg::RESET_BIT;
    end else if (sf_wr) begin
      compare_mux_enable_r <= io_req.wdata[cmp_pkg::SFIO_MUXEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog steering, registered so the macro sees glitch-free selects

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog_sel <= '{power_down: 1'b0, pos_is_bandgap: 1'b0,
                      neg_is_channel: 1'b0, neg_channel: cmp_pkg::RESET_CHAN};
    end else begin
      analog_sel.power_down     <= compare_disable_r; // R9
      analog_sel.pos_is_bandgap <= reference_select_r; // R3
      analog_sel.neg_is_channel <= compare_mux_enable_r && !converter_enable; // R2
      analog_sel.neg_channel    <= channel_select_field; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result synchronisation and edge detection

  logic compare_output_bit;
  logic prev_output_r;

  // The comparator decides analog; the sync stages form its digital view
  cmp_sync #(
    .STAGES   (cmp_pkg::SYNC_STAGES)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (raw_compare),
    .sync_out (compare_output_bit)
  ); // R1 R4

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_output_r <= 1'b0;
    end else begin
      prev_output_r <= compare_output_bit; // R14
    end
  end

  logic rise;
  logic fall;
  logic edge_hit;
  assign rise = compare_output_bit && !prev_output_r;
  assign fall = !compare_output_bit && prev_output_r;

  // Reserved mode raises no event so an unused setting stays quiet
  always_comb begin
    unique case (event_mode_select_r)
      cmp_pkg::MODE_TOGGLE:   edge_hit = rise || fall; // R6
      cmp_pkg::MODE_RESERVED: edge_hit = 1'b0;
      cmp_pkg::MODE_FALLING:  edge_hit = fall; // R6
      cmp_pkg::MODE_RISING:   edge_hit = rise; // R6
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flag: a new edge outranks a clear in the same cycle

  logic flag_clear;
  assign flag_clear = irq_vector_taken ||
                      (cs_wr && io_req.wdata[cmp_pkg::CS_FLAG_BIT]); // R8

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_event_flag_r <= 1'b0;
    end else if (edge_hit) begin
      compare_event_flag_r <= 1'b1; // R5
    end else if (flag_clear) begin
      compare_event_flag_r <= 1'b0; // R8
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_irq <= 1'b0;
    end else begin
      compare_irq <= compare_event_flag_r && compare_irq_enable_r && global_irq_enable; // R7
    end
  end

  // Timer front end does its own filtering and edge choice
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capture_trigger <= 1'b0;
    end else begin
      capture_trigger <= capture_route_enable_r && compare_output_bit; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, registered; unmapped addresses read zero

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (io_req.rd && io_req.addr == cmp_pkg::CTRL_STATUS_OFFSET) begin
      io_rdata <= {compare_disable_r, reference_select_r, compare_output_bit,
                   compare_event_flag_r, compare_irq_enable_r,
                   capture_route_enable_r, event_mode_select_r}; // R1
    end else if (io_req.rd && io_req.addr == cmp_pkg::SFIO_OFFSET) begin
      io_rdata <= {4'h0, compare_mux_enable_r, 3'h0};
    end else begin
      io_rdata <= 8'h00;
    end
  end

endmodule

// >>> verification/cmp_ctrl_asserts.sv
// Checker: port-level properties of the comparator control block
`timescale 1ns/1ps
module cmp_ctrl_asserts (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire cmp_pkg::cmp_io_req_s     io_req,
  input wire logic [7:0]               io_rdata,
  input wire logic                     converter_enable,
  input wire logic [2:0]               channel_select_field,
  input wire logic                     global_irq_enable,
  input wire logic                     irq_vector_taken,
  input wire logic                     raw_compare,
  input wire cmp_pkg::cmp_analog_sel_s analog_sel,
  input wire logic                     compare_irq,
  input wire logic                     capture_trigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ctrl_wr;
    io_req.wr && io_req.addr == cmp_pkg::CTRL_STATUS_OFFSET;
  endsequence
  sequence raw_quiet;
    $stable(raw_compare) [*5];
  endsequence
  ////////////////////////////////////////////////////////////////
  capture_delay_a: assert property (capture_trigger |-> $past(raw_compare, 3))
    else $error("capture high without raw result");
  irq_gate_a: assert property (compare_irq |-> $past(global_irq_enable))
    else $error("interrupt without global enable");
  chan_pick_a: assert property (analog_sel.neg_is_channel |-> !$past(converter_enable))
    else $error("channel picked while converter on");
  chan_field_a: assert property (analog_sel.neg_is_channel |->
    analog_sel.neg_channel == $past(channel_select_field))
    else $error("wrong channel steered");
  power_follow_a: assert property (ctrl_wr |->
    ##2 analog_sel.power_down == $past(io_req.wdata[cmp_pkg::CS_DISABLE_BIT], 2))
    else $error("power down not following write");
  bandgap_follow_a: assert property (ctrl_wr |->
    ##2 analog_sel.pos_is_bandgap == $past(io_req.wdata[cmp_pkg::CS_REFSEL_BIT], 2))
    else $error("reference select not following write");
  sfio_read_a: assert property (io_req.rd && io_req.addr == cmp_pkg::SFIO_OFFSET |=>
    (io_rdata & 8'hf7) == 8'h00)
    else $error("unused special function bits read nonzero");
  vector_clear_a: assert property (raw_quiet ##0 irq_vector_taken |=> ##1 !compare_irq)
    else $error("interrupt stays after vector taken");
endmodule
bind cmp_ctrl cmp_ctrl_asserts cmp_ctrl_asserts_inst (.clk, .rst_n, .io_req, .io_rdata,
  .converter_enable, .channel_select_field, .global_irq_enable, .irq_vector_taken,
  .raw_compare, .analog_sel, .compare_irq, .capture_trigger);

// >>> verification/cmp_analog_model.sv
// Analog front end model: input pins, bandgap and the comparator macro
`timescale 1ns/1ps
module cmp_analog_model #(
  parameter int BANDGAP_MV = 1100
) (
  input wire cmp_pkg::cmp_analog_sel_s sel,
  input wire logic [11:0]              pos_mv,
  input wire logic [11:0]              neg_mv,
  input wire logic [95:0]              chan_mv,
  output logic                         raw
);
  logic [11:0] p;
  logic [11:0] n;
  assign p = sel.pos_is_bandgap ? 12'(BANDGAP_MV) : pos_mv;
  assign n = sel.neg_is_channel ? chan_mv[sel.neg_channel*12 +: 12] : neg_mv;
  // Unpowered macro reads low, so power-down shows at the ports
  assign raw = !sel.power_down && p > n;
endmodule

// >>> verification/tb_cmp_ctrl.sv
// Testbench: registers, input steering and edge events of cmp_ctrl
`timescale 1ns/1ps
module tb_cmp_ctrl;
  localparam logic [5:0]  CS = cmp_pkg::CTRL_STATUS_OFFSET;
  localparam logic [5:0]  SF = cmp_pkg::SFIO_OFFSET;
  localparam logic [11:0] BG = 12'h44c;
  logic clk = 0, rst_n = 0, cen = 1, gie = 0, vec = 0, irq, cap, raw;
  logic [2:0]  chs = 0;
  logic [7:0]  rd;
  logic [11:0] pmv = 12'h100, nmv = 12'h200;
  logic [95:0] cmv = '0;
  logic [31:0] seed = 32'h3cc6c6b3;
  cmp_pkg::cmp_io_req_s     req = '0;
  cmp_pkg::cmp_analog_sel_s asel;
  int fails = 0, checked = 0;
  always #5 clk = ~clk;
  cmp_ctrl cmp_ctrl_inst (.clk, .rst_n, .io_req(req), .io_rdata(rd), .converter_enable(cen),
    .channel_select_field(chs), .global_irq_enable(gie), .irq_vector_taken(vec),
    .raw_compare(raw), .analog_sel(asel), .compare_irq(irq), .capture_trigger(cap));
  cmp_analog_model #(.BANDGAP_MV(int'(BG))) cmp_analog_model_inst (.sel(asel), .pos_mv(pmv),
    .neg_mv(nmv), .chan_mv(cmv), .raw(raw));
  ////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic flag_exp(logic [1:0] m, logic rise);
    return m == cmp_pkg::MODE_TOGGLE || m == (rise ? cmp_pkg::MODE_RISING : cmp_pkg::MODE_FALLING);
  endfunction
  function logic out_exp(logic bg, logic mux);
    return (bg ? BG : pmv) > ((mux && !cen) ? cmv[chs*12 +: 12] : nmv);
  endfunction
  task chk(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task io(logic w, logic [5:0] a, logic [7:0] d);
    @(negedge clk);
    req = '{w, !w, a, d};
    @(negedge clk);
    req = '0;
  endtask
  task close_out();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    logic [7:0] w;
    repeat (3) @(negedge clk);
    rst_n = 1;
    io(0, CS, 0); chk(rd, 8'h00);
    repeat (4) begin
      w = rnd();
      // Interrupt enable kept off while power and mode change
      io(1, CS, (w & 8'h87) | 8'h30); io(0, CS, 0); chk(rd, w & 8'h87);
      io(1, SF, w); io(0, SF, 0); chk(rd, w & 8'h08);
      io(1, {w[7:6], 4'h5}, w); io(0, {w[7:6], 4'h5}, 0); chk(rd, 8'h00);
    end
    gie = 1;
    for (int m = 0; m < 4; m++) begin
      io(1, CS, 8'h14 | 8'(m)); io(1, CS, 8'h1c | 8'(m));
      pmv = 12'h300;
      repeat (4) @(negedge clk);
      io(0, CS, 0); chk(rd, 8'h2c | 8'(m) | {3'h0, flag_exp(m[1:0], 1), 4'h0});
      chk({7'h0, irq}, {7'h0, flag_exp(m[1:0], 1)});
      chk({7'h0, cap}, 8'h01);
      io(1, CS, 8'h1c | 8'(m));
      pmv = 12'h100;
      repeat (4) @(negedge clk);
      io(0, CS, 0); chk(rd, 8'h0c | 8'(m) | {3'h0, flag_exp(m[1:0], 0), 4'h0});
      vec = 1;
      @(negedge clk) vec = 0;
      io(0, CS, 0); chk(rd, 8'h0c | 8'(m));
      chk({7'h0, irq}, 8'h00);
    end
    // Reserved mode keeps random steering from setting the flag
    io(1, CS, 8'h01);
    repeat (8) begin
      w = rnd();
      cen = w[3];
      chs = w[2:0];
      pmv = rnd();
      cmv = {rnd(), rnd(), rnd()};
      io(1, SF, {4'h0, w[5], 3'h0});
      io(1, CS, {1'b0, w[4], 6'h11});
      repeat (3) @(negedge clk);
      io(0, CS, 0); chk(rd, {1'b0, w[4], out_exp(w[4], w[5]), 5'h01});
      chk({7'h0, cap}, 8'h00);
    end
    close_out();
  end
endmodule
